// ===== src/arl_pkg.sv
package arl_pkg;
	// ----------------------------------------------------------------
	// channel counts and data layout
	// ----------------------------------------------------------------
	localparam int NUM_CELLS = 12;
	localparam int NUM_AUX = 2;
	localparam int NUM_CH = 14;
	localparam int VAL_W = 14;
	localparam int WORD_W = 16;
	localparam int NUM_WORDS = 16;
	localparam int ADDR_W = 4;
	localparam int SUM_W = 18;
	localparam int CELL_NUM_W = 4;
	// measurement value sits in the upper bits of a data word
	localparam int VAL_LSB = 2;
	localparam logic [VAL_LSB-1:0] VAL_PAD = 2'h0;
	// word slots in the result bank
	localparam int WORD_AUX0 = 12;
	localparam int WORD_INDEX = 14;
	localparam int WORD_TOTAL = 15;
	// extreme cell index word: min cell in low nibble, max cell in third nibble
	localparam int IDX_MIN_LSB = 0;
	localparam int IDX_MAX_LSB = 8;
	// spread threshold reset value disables the spread alert
	localparam logic [WORD_W-1:0] SPREAD_THR_RST = 16'hfffc;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLK_HZ = 25_000_000;
	localparam int REC_TIME_NS = 100300;
	localparam int REC_CYCLES = (REC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REC_CNT_W = 12;
	localparam int SEC_W = 25;
	localparam int PER_W = 9;
	localparam int CNT_W = 4;

	// ----------------------------------------------------------------
	// balance watchdog prescaler codes and periods in seconds
	// ----------------------------------------------------------------
	localparam logic [2:0] PDIV_OFF = 3'h0;
	localparam logic [2:0] PDIV_1S = 3'h1;
	localparam logic [2:0] PDIV_4S = 3'h2;
	localparam logic [2:0] PDIV_16S = 3'h3;
	localparam logic [2:0] PDIV_64S = 3'h4;
	localparam logic [2:0] PDIV_128S = 3'h5;
	localparam logic [2:0] PDIV_256S = 3'h6;
	localparam logic [PER_W-1:0] PER_SEC_1 = 9'h001;
	localparam logic [PER_W-1:0] PER_SEC_4 = 9'h004;
	localparam logic [PER_W-1:0] PER_SEC_16 = 9'h010;
	localparam logic [PER_W-1:0] PER_SEC_64 = 9'h040;
	localparam logic [PER_W-1:0] PER_SEC_128 = 9'h080;
	localparam logic [PER_W-1:0] PER_SEC_256 = 9'h100;

	// zero period marks a disabled timer
	function automatic logic [PER_W-1:0] arl_period_sec(input logic [2:0] code);
		logic [PER_W-1:0] p;
		p = '0;
		case (code)
			PDIV_1S: p = PER_SEC_1;
			PDIV_4S: p = PER_SEC_4;
			PDIV_16S: p = PER_SEC_16;
			PDIV_64S: p = PER_SEC_64;
			PDIV_128S: p = PER_SEC_128;
			PDIV_256S: p = PER_SEC_256;
			default: p = '0;
		endcase
		return p;
	endfunction
endpackage

// ===== src/arl_result_bank.sv
`timescale 1ns/1ps
module arl_result_bank import arl_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// parallel load
	input wire logic load_i,
	input wire logic [NUM_WORDS*WORD_W-1:0] load_data_i,
	// read port
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output logic [WORD_W-1:0] rd_data_o
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] words_q [NUM_WORDS];
	logic [WORD_W-1:0] words_d [NUM_WORDS];
	logic [WORD_W-1:0] rd_data_q, rd_data_d;

	// every word loads on the same edge, never one after another
	for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
		always_comb begin
			words_d[w] = load_i ? load_data_i[w*WORD_W +: WORD_W] : words_q[w];
		end
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				words_q[w] <= '0;
			end else begin
				words_q[w] <= words_d[w];
			end
		end
	end

	// registered read, one cycle after the address
	always_comb begin
		rd_data_d = words_q[rd_addr_i];
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_q <= '0;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	assign rd_data_o = rd_data_q;
endmodule

// ===== src/arl_top.sv
`timescale 1ns/1ps
// Summary of operation
// - with oversampling, hold a 100.3 us recovery after each cycle except the last
// - by default copy all ALU results to data registers at acquisition end
// - all data registers load together in one parallel transfer
// - every transfer sets the results ready flag
// - double buffering defers the automatic transfer to the next acquisition start
// - a manual transfer strobe copies ALU results into the data registers
// - manual transfer is ignored while an acquisition runs; host checks done flag
// - cell alerts are evaluated after the measurement cycle, before any transfer; aux alerts at acquisition end
// - with oversampling, alerts update once, after the final oversample
// - alerts update regardless of transfer, only for enabled channels
// - per cell, set high flag above high set, low flag below low set
// - flags clear only past their clear threshold; equality changes nothing
// - summaries OR all flags; combined bit ORs a cell's high and low flags
// - spread alert set when max minus min exceeds threshold, else cleared
// - spread threshold resets to a value that disables the alert
// - record min and max cell indices; ties report the highest position
// - store the sum of enabled cell voltages as a 16-bit total
// - with no cell enabled, index and total stay unchanged
// - aux cold above cold limit, hot below hot limit, no hysteresis
// - an expired balance watchdog forces switches off, stored enables untouched
// - prescaler sets countdown step: off, 1, 4, 16, 64, 128, 256 s
// - at zero, switches stay off until a non-zero write or timer disable
module arl_top import arl_pkg::*; #(
	parameter int SECOND_CYCLES = CLK_HZ
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// acquisition sequencer events
	input wire logic acq_start_i,
	input wire logic meas_cycle_done_i,
	input wire logic last_cycle_i,
	input wire logic acq_end_i,
	// ALU results
	input wire logic [NUM_CELLS*VAL_W-1:0] alu_cells_i,
	input wire logic [NUM_AUX*VAL_W-1:0] alu_aux_i,
	// acquisition configuration
	input wire logic oversample_en_i,
	input wire logic double_buffer_enable_i,
	input wire logic manual_transfer_strobe_i,
	input wire logic results_ready_clr_i,
	input wire logic [NUM_CH-1:0] channel_enables_i,
	input wire logic [NUM_CH-1:0] high_alert_enables_i,
	input wire logic [NUM_CH-1:0] low_alert_enables_i,
	// thresholds
	input wire logic [VAL_W-1:0] high_set_threshold_i,
	input wire logic [VAL_W-1:0] high_clear_threshold_i,
	input wire logic [VAL_W-1:0] low_set_threshold_i,
	input wire logic [VAL_W-1:0] low_clear_threshold_i,
	input wire logic [VAL_W-1:0] cold_limit_threshold_i,
	input wire logic [VAL_W-1:0] hot_limit_threshold_i,
	input wire logic spread_threshold_wr_i,
	input wire logic [WORD_W-1:0] spread_threshold_data_i,
	// balance watchdog
	input wire logic [NUM_CELLS-1:0] balance_switch_enables_i,
	input wire logic [2:0] balance_timer_prescaler_i,
	input wire logic balance_countdown_wr_i,
	input wire logic [CNT_W-1:0] balance_countdown_data_i,
	// data read port
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output logic [WORD_W-1:0] rd_data_o,
	// status
	output logic hv_recovery_o,
	output logic acquisition_done_flag_o,
	output logic results_ready_flag_o,
	output logic [NUM_CELLS-1:0] per_cell_high_flags_o,
	output logic [NUM_CELLS-1:0] per_cell_low_flags_o,
	output logic [NUM_CELLS-1:0] per_cell_combined_alert_o,
	output logic any_cell_high_summary_o,
	output logic any_cell_low_summary_o,
	output logic spread_alert_o,
	output logic [WORD_W-1:0] spread_threshold_o,
	output logic [NUM_AUX-1:0] aux_cold_flags_o,
	output logic [NUM_AUX-1:0] aux_hot_flags_o,
	output logic cold_alert_o,
	output logic hot_alert_o,
	// balance outputs
	output logic [NUM_CELLS-1:0] balance_switch_drive_o,
	output logic [CNT_W-1:0] balance_countdown_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ----------------------------------------------------------------
	// acquisition tracking and transfer
	// ----------------------------------------------------------------
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic ready_q, ready_d;
	logic pending_q, pending_d;
	logic xfer;
	logic manual_ok;

	// manual move refused during a scan; the host polls the done flag
	assign manual_ok = manual_transfer_strobe_i && !busy_q && !acq_start_i;
	// double buffering moves last results as the next scan starts
	assign xfer = (acq_end_i && !double_buffer_enable_i)
		|| (acq_start_i && double_buffer_enable_i && pending_q)
		|| manual_ok;

	// flag updates: a set in the clearing cycle wins
	always_comb begin
		busy_d = busy_q;
		done_d = done_q;
		ready_d = ready_q;
		pending_d = pending_q;
		if (acq_start_i) begin
			busy_d = 1'b1;
			done_d = 1'b0;
		end
		if (acq_end_i) begin
			busy_d = 1'b0;
			done_d = 1'b1;
		end
		if (results_ready_clr_i) begin
			ready_d = 1'b0;
		end
		if (xfer) begin
			ready_d = 1'b1;
			pending_d = 1'b0;
		end
		if (acq_end_i && double_buffer_enable_i) begin
			pending_d = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			ready_q <= 1'b0;
			pending_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
			done_q <= done_d;
			ready_q <= ready_d;
			pending_q <= pending_d;
		end
	end

	// ----------------------------------------------------------------
	// HV recovery interval
	// ----------------------------------------------------------------
	logic rec_q, rec_d;
	logic [REC_CNT_W-1:0] rec_cnt_q, rec_cnt_d;
	logic rec_trig;

	assign rec_trig = meas_cycle_done_i && oversample_en_i && !last_cycle_i;

	// recovery runs a fixed count; sequencer waits on the level
	always_comb begin
		rec_d = rec_q;
		rec_cnt_d = rec_cnt_q;
		if (rec_trig && !rec_q) begin
			rec_d = 1'b1;
			rec_cnt_d = '0;
		end else if (rec_q) begin
			if (rec_cnt_q == REC_CNT_W'(REC_CYCLES - 1)) begin
				rec_d = 1'b0;
			end else begin
				rec_cnt_d = rec_cnt_q + 1'b1;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rec_q <= 1'b0;
			rec_cnt_q <= '0;
		end else begin
			rec_q <= rec_d;
			rec_cnt_q <= rec_cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// cell alerts
	// ----------------------------------------------------------------
	logic cell_eval;
	logic [VAL_W-1:0] cell_v [NUM_CELLS];
	logic [NUM_CELLS-1:0] hi_q, hi_d, lo_q, lo_d;
	logic [NUM_CELLS*WORD_W-1:0] cell_words;

	// once per cycle, or only after the last oversample
	assign cell_eval = meas_cycle_done_i && (!oversample_en_i || last_cycle_i);

	for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
		assign cell_v[i] = alu_cells_i[i*VAL_W +: VAL_W];
		assign cell_words[i*WORD_W +: WORD_W] = {cell_v[i], VAL_PAD};
		// hysteresis: strict compares, equality holds the flag
		assign hi_d[i] = !(cell_eval && channel_enables_i[i]) ? hi_q[i]
			: (high_alert_enables_i[i] && cell_v[i] > high_set_threshold_i) ? 1'b1
			: (cell_v[i] < high_clear_threshold_i) ? 1'b0 : hi_q[i];
		assign lo_d[i] = !(cell_eval && channel_enables_i[i]) ? lo_q[i]
			: (low_alert_enables_i[i] && cell_v[i] < low_set_threshold_i) ? 1'b1
			: (cell_v[i] > low_clear_threshold_i) ? 1'b0 : lo_q[i];
	end

	// ----------------------------------------------------------------
	// cell statistics
	// ----------------------------------------------------------------
	logic [VAL_W-1:0] min_v, max_v;
	logic [CELL_NUM_W-1:0] min_idx, max_idx;
	logic [SUM_W-1:0] sum_v;
	logic any_cell;
	logic [WORD_W-1:0] index_q, index_d, total_q, total_d;
	logic spread_q, spread_d;
	logic [WORD_W-1:0] spread_thr_q, spread_thr_d;

	// ascending scan with <= and >= lets the highest position win ties
	always_comb begin
		min_v = '1;
		max_v = '0;
		min_idx = '0;
		max_idx = '0;
		sum_v = '0;
		any_cell = 1'b0;
		for (int k = 0; k < NUM_CELLS; k++) begin
			if (channel_enables_i[k]) begin
				any_cell = 1'b1;
				sum_v = sum_v + SUM_W'(cell_v[k]);
				if (cell_v[k] <= min_v) begin
					min_v = cell_v[k];
					min_idx = CELL_NUM_W'(k + 1);
				end
				if (cell_v[k] >= max_v) begin
					max_v = cell_v[k];
					max_idx = CELL_NUM_W'(k + 1);
				end
			end
		end
	end

	// statistics and spread update only when some cell took part
	always_comb begin
		index_d = index_q;
		total_d = total_q;
		spread_d = spread_q;
		spread_thr_d = spread_threshold_wr_i ? spread_threshold_data_i : spread_thr_q;
		if (cell_eval && any_cell) begin
			index_d = '0;
			index_d[IDX_MIN_LSB +: CELL_NUM_W] = min_idx;
			index_d[IDX_MAX_LSB +: CELL_NUM_W] = max_idx;
			total_d = sum_v[SUM_W-1 -: WORD_W];
			// full-scale threshold can never be exceeded
			spread_d = (max_v - min_v) > spread_thr_q[WORD_W-1:VAL_LSB];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			index_q <= '0;
			total_q <= '0;
			spread_q <= 1'b0;
			spread_thr_q <= SPREAD_THR_RST;
		end else begin
			index_q <= index_d;
			total_q <= total_d;
			spread_q <= spread_d;
			spread_thr_q <= spread_thr_d;
		end
	end

	// ----------------------------------------------------------------
	// auxiliary temperature alerts
	// ----------------------------------------------------------------
	logic [NUM_AUX-1:0] cold_q, cold_d, hot_q, hot_d;
	logic [NUM_AUX*WORD_W-1:0] aux_words;

	// aux inputs convert last, so judge them at acquisition end
	for (genvar j = 0; j < NUM_AUX; j++) begin : g_aux
		logic [VAL_W-1:0] av;
		logic upd;
		assign av = alu_aux_i[j*VAL_W +: VAL_W];
		assign aux_words[j*WORD_W +: WORD_W] = {av, VAL_PAD};
		assign upd = acq_end_i && channel_enables_i[NUM_CELLS + j];
		assign cold_d[j] = (upd && high_alert_enables_i[NUM_CELLS + j])
			? (av > cold_limit_threshold_i) : cold_q[j];
		assign hot_d[j] = (upd && low_alert_enables_i[NUM_CELLS + j])
			? (av < hot_limit_threshold_i) : hot_q[j];
	end

	// alert flops, summaries taken from next values so outputs stay flops
	logic sum_hi_q, sum_lo_q, cold_any_q, hot_any_q;
	logic [NUM_CELLS-1:0] comb_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hi_q <= '0;
			lo_q <= '0;
			comb_q <= '0;
			sum_hi_q <= 1'b0;
			sum_lo_q <= 1'b0;
			cold_q <= '0;
			hot_q <= '0;
			cold_any_q <= 1'b0;
			hot_any_q <= 1'b0;
		end else begin
			hi_q <= hi_d;
			lo_q <= lo_d;
			comb_q <= hi_d | lo_d;
			sum_hi_q <= |hi_d;
			sum_lo_q <= |lo_d;
			cold_q <= cold_d;
			hot_q <= hot_d;
			cold_any_q <= |cold_d;
			hot_any_q <= |hot_d;
		end
	end

	// ----------------------------------------------------------------
	// result bank
	// ----------------------------------------------------------------
	arl_result_bank u_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(xfer),
		.load_data_i({total_q, index_q, aux_words, cell_words}),
		.rd_addr_i(rd_addr_i),
		.rd_data_o(rd_data_o)
	);

	// ----------------------------------------------------------------
	// balance watchdog
	// ----------------------------------------------------------------
	logic [SEC_W-1:0] sec_q, sec_d;
	logic [PER_W-1:0] per_q, per_d, period;
	logic [CNT_W-1:0] cd_q, cd_d;
	logic [NUM_CELLS-1:0] drive_q, drive_d;
	logic wd_en, wd_block;

	// zero period covers code 000b and the undefined 111b
	assign period = arl_period_sec(balance_timer_prescaler_i);
	assign wd_en = (period != '0);

	// seconds prescale, then period steps, then countdown
	always_comb begin
		sec_d = sec_q;
		per_d = per_q;
		cd_d = cd_q;
		if (balance_countdown_wr_i) begin
			cd_d = balance_countdown_data_i;
			sec_d = '0;
			per_d = '0;
		end else if (!wd_en || cd_q == '0) begin
			sec_d = '0;
			per_d = '0;
		end else if (sec_q == SEC_W'(SECOND_CYCLES - 1)) begin
			sec_d = '0;
			if (per_q == period - 1'b1) begin
				per_d = '0;
				cd_d = cd_q - 1'b1;
			end else begin
				per_d = per_q + 1'b1;
			end
		end else begin
			sec_d = sec_q + 1'b1;
		end
		wd_block = wd_en && (cd_d == '0);
		// gate only the drive; host enables stay as written
		drive_d = wd_block ? '0 : balance_switch_enables_i;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sec_q <= '0;
			per_q <= '0;
			cd_q <= '0;
			drive_q <= '0;
		end else begin
			sec_q <= sec_d;
			per_q <= per_d;
			cd_q <= cd_d;
			drive_q <= drive_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign hv_recovery_o = rec_q;
	assign acquisition_done_flag_o = done_q;
	assign results_ready_flag_o = ready_q;
	assign per_cell_high_flags_o = hi_q;
	assign per_cell_low_flags_o = lo_q;
	assign per_cell_combined_alert_o = comb_q;
	assign any_cell_high_summary_o = sum_hi_q;
	assign any_cell_low_summary_o = sum_lo_q;
	assign spread_alert_o = spread_q;
	assign spread_threshold_o = spread_thr_q;
	assign aux_cold_flags_o = cold_q;
	assign aux_hot_flags_o = hot_q;
	assign cold_alert_o = cold_any_q;
	assign hot_alert_o = hot_any_q;
	assign balance_switch_drive_o = drive_q;
	assign balance_countdown_o = cd_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_rec_trig;
		rec_trig && !rec_q;
	endsequence
	AST_REC_START: assert property (s_rec_trig |=> hv_recovery_o ##1 hv_recovery_o)
		else $error("recovery did not start");
	AST_REC_LEN: assert property ($fell(hv_recovery_o) |-> $past(rec_cnt_q) == REC_CNT_W'(REC_CYCLES - 1))
		else $error("recovery length wrong");
	AST_AUTO_XFER: assert property (acq_end_i && !double_buffer_enable_i |=> results_ready_flag_o)
		else $error("auto transfer did not flag ready");
	AST_DBL_DEFER: assert property (acq_end_i && double_buffer_enable_i && !manual_ok |-> !xfer)
		else $error("double buffer transferred at end");
	AST_MAN_BUSY: assert property (busy_q && !acq_start_i && !acq_end_i |-> !xfer)
		else $error("manual transfer during scan");
	AST_OVS_ONCE: assert property (rec_trig |=> $stable(per_cell_high_flags_o) && $stable(per_cell_low_flags_o))
		else $error("alerts updated mid oversampling");
	AST_HIGH_SET: assert property (cell_eval && channel_enables_i[4] && high_alert_enables_i[4]
		&& cell_v[4] > high_set_threshold_i |=> per_cell_high_flags_o[4] && any_cell_high_summary_o)
		else $error("high flag not set");
	AST_EQ_HOLD: assert property (cell_eval && channel_enables_i[4] && cell_v[4] == high_clear_threshold_i
		&& cell_v[4] <= high_set_threshold_i |=> $stable(per_cell_high_flags_o[4]))
		else $error("equal value changed flag");
	AST_NO_CELL: assert property (cell_eval && channel_enables_i[NUM_CELLS-1:0] == '0 |=> $stable(index_q)
		&& $stable(total_q))
		else $error("statistics changed without cells");
	AST_WDOG_OFF: assert property (wd_en && cd_q == '0 && !balance_countdown_wr_i |=> balance_switch_drive_o == '0)
		else $error("switches on after expiry");
endmodule

// ===== tb/arl_testbench.sv
`timescale 1ns/1ps
module testbench import arl_pkg::*; ;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	localparam int SEC = 10; // short second keeps the watchdog run brief
	logic clk_i = 0, rst_i = 1, acq_start_i = 0, meas_cycle_done_i = 0, last_cycle_i = 0, acq_end_i = 0;
	logic oversample_en_i = 0, double_buffer_enable_i = 0, manual_transfer_strobe_i = 0, results_ready_clr_i = 0;
	logic spread_threshold_wr_i = 0, balance_countdown_wr_i = 0;
	logic [NUM_CELLS*VAL_W-1:0] alu_cells_i;
	logic [NUM_AUX*VAL_W-1:0] alu_aux_i = {2{14'h2000}};
	logic [NUM_CH-1:0] channel_enables_i = 14'h3fff, high_alert_enables_i = 14'h3fff, low_alert_enables_i = 14'h3fff;
	logic [VAL_W-1:0] high_set_threshold_i = 14'h3000, high_clear_threshold_i = 14'h2800;
	logic [VAL_W-1:0] low_set_threshold_i = 14'h0800, low_clear_threshold_i = 14'h1000;
	logic [VAL_W-1:0] cold_limit_threshold_i = 14'h3fff, hot_limit_threshold_i = 14'h0000;
	logic [WORD_W-1:0] spread_threshold_data_i = 16'h0000;
	logic [NUM_CELLS-1:0] balance_switch_enables_i = 12'habc;
	logic [2:0] balance_timer_prescaler_i = 3'h0;
	logic [CNT_W-1:0] balance_countdown_data_i = 4'h0;
	logic [ADDR_W-1:0] rd_addr_i = 4'h0;
	logic [WORD_W-1:0] rd_data_o, spread_threshold_o;
	logic hv_recovery_o, acquisition_done_flag_o, results_ready_flag_o, any_cell_high_summary_o;
	logic any_cell_low_summary_o, spread_alert_o, cold_alert_o, hot_alert_o;
	logic [NUM_CELLS-1:0] per_cell_high_flags_o, per_cell_low_flags_o, per_cell_combined_alert_o, balance_switch_drive_o;
	logic [NUM_AUX-1:0] aux_cold_flags_o, aux_hot_flags_o;
	logic [CNT_W-1:0] balance_countdown_o;
	logic [VAL_W-1:0] cv [NUM_CELLS];
	int n_mismatch = 0, n_checks = 0;

	always #20 clk_i = ~clk_i;
	// cell results packed cell1 first
	always_comb for (int i = 0; i < NUM_CELLS; i++) alu_cells_i[i*VAL_W+:VAL_W] = cv[i];

	arl_top #(.SECOND_CYCLES(SEC)) dut (.clk_i, .rst_i, .acq_start_i, .meas_cycle_done_i, .last_cycle_i, .acq_end_i,
		.alu_cells_i, .alu_aux_i, .oversample_en_i, .double_buffer_enable_i, .manual_transfer_strobe_i,
		.results_ready_clr_i, .channel_enables_i, .high_alert_enables_i, .low_alert_enables_i,
		.high_set_threshold_i, .high_clear_threshold_i, .low_set_threshold_i, .low_clear_threshold_i,
		.cold_limit_threshold_i, .hot_limit_threshold_i, .spread_threshold_wr_i, .spread_threshold_data_i,
		.balance_switch_enables_i, .balance_timer_prescaler_i, .balance_countdown_wr_i, .balance_countdown_data_i,
		.rd_addr_i, .rd_data_o, .hv_recovery_o, .acquisition_done_flag_o, .results_ready_flag_o,
		.per_cell_high_flags_o, .per_cell_low_flags_o, .per_cell_combined_alert_o, .any_cell_high_summary_o,
		.any_cell_low_summary_o, .spread_alert_o, .spread_threshold_o, .aux_cold_flags_o, .aux_hot_flags_o,
		.cold_alert_o, .hot_alert_o, .balance_switch_drive_o, .balance_countdown_o);

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one-cycle pulse, then a quiet cycle so events never abut
	task automatic pulse(ref logic s);
		s = 1;
		@(negedge clk_i);
		s = 0;
		@(negedge clk_i);
	endtask
	task automatic run_acq;
		pulse(acq_start_i);
		last_cycle_i = 1;
		pulse(meas_cycle_done_i);
		last_cycle_i = 0;
		pulse(acq_end_i);
	endtask
	// read data is registered, so check two cycles after setting the address
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		rd_addr_i = a;
		@(negedge clk_i);
		@(negedge clk_i);
		chk(rd_data_o, e);
	endtask
	// expected total from enabled cells only
	function automatic logic [15:0] tot();
		logic [17:0] s;
		s = '0;
		for (int i = 0; i < NUM_CELLS; i++) if (channel_enables_i[i]) s += 18'(cv[i]);
		return s[17:2];
	endfunction
	task automatic end_of_test;
		if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_auto;
		cv[0] = 14'h0700; cv[2] = 14'h0700; cv[4] = 14'h3001; cv[9] = 14'h3001;
		run_acq;
		chk(16'(results_ready_flag_o), 16'h1);
		chk(16'(per_cell_high_flags_o), 16'h0210);
		chk(16'(per_cell_low_flags_o), 16'h0005);
		chk(16'(per_cell_combined_alert_o), 16'h0215);
		chk(16'({any_cell_high_summary_o, any_cell_low_summary_o, spread_alert_o}), 16'h6);
		rd(4'h4, {cv[4], VAL_PAD});
		rd(4'he, 16'h0a03);
		rd(4'hf, tot());
	endtask
	task automatic t_hyst;
		cv[0] = 14'h2000; cv[2] = 14'h1000; cv[4] = 14'h2800; cv[9] = 14'h27ff;
		channel_enables_i = 14'h3ffe; // cell1 off: its flag must hold
		cold_limit_threshold_i = 14'h1fff;
		hot_limit_threshold_i = 14'h2001;
		run_acq;
		chk(16'(per_cell_high_flags_o), 16'h0010);
		chk(16'(per_cell_low_flags_o), 16'h0005);
		rd(4'he, 16'h0503);
		rd(4'hf, tot());
		chk(16'({cold_alert_o, hot_alert_o, aux_cold_flags_o, aux_hot_flags_o}), 16'h003f);
		rd(4'hc, 16'h8000);
		cold_limit_threshold_i = 14'h3fff;
		hot_limit_threshold_i = 14'h0000;
		channel_enables_i = 14'h3fff;
	endtask
	task automatic t_spread;
		logic [15:0] e;
		spread_threshold_data_i = 16'h0400;
		pulse(spread_threshold_wr_i);
		chk(spread_threshold_o, 16'h0400);
		for (int i = 0; i < NUM_CELLS; i++) cv[i] = 14'h2000;
		cv[6] = 14'h2101;
		run_acq;
		chk(16'(spread_alert_o), 16'h1);
		chk(16'({cold_alert_o, hot_alert_o}), 16'h0);
		cv[6] = 14'h2100;
		run_acq;
		chk(16'(spread_alert_o), 16'h0);
		e = tot();
		channel_enables_i = 14'h3000;
		cv[6] = 14'h0000;
		run_acq;
		rd(4'hf, e);
		rd(4'he, 16'h070c);
		channel_enables_i = 14'h3fff;
		cv[6] = 14'h2000;
	endtask
	task automatic t_dbl;
		double_buffer_enable_i = 1;
		pulse(results_ready_clr_i);
		cv[0] = 14'h1234;
		run_acq;
		chk(16'(results_ready_flag_o), 16'h0);
		rd(4'h0, 16'h8000);
		pulse(acq_start_i);
		chk(16'(results_ready_flag_o), 16'h1);
		chk(16'(acquisition_done_flag_o), 16'h0);
		rd(4'h0, 16'h48d0);
		pulse(results_ready_clr_i);
		pulse(manual_transfer_strobe_i);
		chk(16'(results_ready_flag_o), 16'h0);
		last_cycle_i = 1;
		pulse(meas_cycle_done_i);
		last_cycle_i = 0;
		pulse(acq_end_i);
		chk(16'(acquisition_done_flag_o), 16'h1);
		pulse(manual_transfer_strobe_i);
		chk(16'(results_ready_flag_o), 16'h1);
		double_buffer_enable_i = 0;
	endtask
	task automatic t_recov;
		int n;
		n = 0;
		cv[0] = 14'h2000; cv[3] = 14'h3100;
		oversample_en_i = 1;
		pulse(acq_start_i);
		meas_cycle_done_i = 1;
		for (int i = 0; i < 2520; i++) begin
			@(negedge clk_i);
			meas_cycle_done_i = 0;
			if (hv_recovery_o === 1'b1) n++;
		end
		chk(16'(n), 16'(REC_CYCLES));
		chk(16'(per_cell_high_flags_o), 16'h0000);
		run_acq;
		chk(16'(hv_recovery_o), 16'h0);
		chk(16'(per_cell_high_flags_o), 16'h0008);
		oversample_en_i = 0;
	endtask
	task automatic t_wdog;
		int p [6] = '{1, 4, 16, 64, 128, 256};
		balance_timer_prescaler_i = 3'h7;
		repeat (2) @(negedge clk_i);
		chk(16'(balance_switch_drive_o), 16'h0abc);
		for (int c = 0; c < 6; c++) begin
			balance_timer_prescaler_i = 3'(c + 1);
			balance_countdown_data_i = 4'h1;
			pulse(balance_countdown_wr_i);
			chk(16'(balance_switch_drive_o), 16'h0abc);
			repeat (p[c] * SEC - 4) @(negedge clk_i);
			chk(16'(balance_countdown_o), 16'h1);
			repeat (5) @(negedge clk_i);
			chk(16'(balance_countdown_o), 16'h0);
			chk(16'(balance_switch_drive_o), 16'h0000);
		end
		balance_timer_prescaler_i = 3'h0;
		repeat (2) @(negedge clk_i);
		chk(16'(balance_switch_drive_o), 16'h0abc);
	endtask

	// ----------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------
	initial begin
		for (int i = 0; i < NUM_CELLS; i++) cv[i] = 14'h2000;
		repeat (6) @(negedge clk_i);
		rst_i = 0;
		@(negedge clk_i);
		chk(spread_threshold_o, SPREAD_THR_RST);
		chk(16'(balance_switch_drive_o), 16'h0abc);
		t_auto;
		t_hyst;
		t_spread;
		t_dbl;
		t_recov;
		t_wdog;
		end_of_test;
	end
	// whole run needs roughly 7300 cycles
	initial begin
		#(40 * 20000);
		n_mismatch++;
		end_of_test;
	end
endmodule
